// File: rtl/clk_div.sv
`timescale 1ns/1ps
module clk_div #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_div,
    output logic o_tick
);
    logic [W-1:0] cnt_reg;
    wire logic at_end = (cnt_reg == '0);
    // a ratio of zero runs like one so the output never stalls
    wire logic [W-1:0] reload = (i_div == '0) ? '0 : i_div - W'(1);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            cnt_reg <= '0;
        else
            cnt_reg <= at_end ? reload : cnt_reg - W'(1);
    end

    assign o_tick = at_end;
endmodule

// File: rtl/clock_power_manager.sv
// Operation
// - both loops off and powered down after reset
// - main loop reference rc or osc; alternate osc
// - loop output divider never below two
// - usb from main loop, alternate as option
// - per-clock source select plus following dividers
// - wait rc start-up on power-down wake
// - four rc cycles before code resumes
// - flash timer blocks flash until expiry
// - deep power-down powers off main domain
// - option keeps slow oscillator powered in deep
// - deep power-down exits on reset or alarm
// - wake mask captured on low-power entry
// - masked interrupt restarts processor without polling
// - watchdog oscillator clocks watchdog independently
// - watchdog oscillator runs while watchdog enabled
// - rtc gives second tick and slow clock
// - clock output can show watchdog oscillator
// - each peripheral has its own power off
// - backup domain stays powered when main off
`timescale 1ns/1ps
module clock_power_manager #(
    parameter int IRQ_N = 32,
    parameter int START_CYC = cpm_pkg::IRC_START_CYC,
    parameter int FLASH_CYC = cpm_pkg::FLASH_START_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic i_main_pll_lock,
    input wire logic i_alt_pll_lock,
    input wire logic [IRQ_N-1:0] i_irq_pend,
    input wire logic [IRQ_N-1:0] i_irq_mask,
    input wire logic i_rtc_alarm,
    input wire logic i_rtc_32k,
    input wire logic i_rtc_1hz,
    input wire logic i_wdt_osc,
    input wire logic i_wdt_en,
    output logic [31:0] o_rdata,
    output logic o_main_pll_pd,
    output logic o_alt_pll_pd,
    output logic o_main_pll_ref_osc,
    output logic [7:0] o_main_pll_mult,
    output logic [7:0] o_main_pll_div,
    output logic [7:0] o_alt_pll_mult,
    output logic [7:0] o_alt_pll_div,
    output logic [1:0] o_cpu_src,
    output logic o_cpu_clk_tick,
    output logic o_usb_from_alt,
    output logic o_usb_clk_tick,
    output logic o_clock_output_pin,
    output logic o_rtc_tick,
    output logic o_wdt_osc_en,
    output logic [31:0] o_periph_pwr_on,
    output logic o_main_domain_pwr,
    output logic o_backup_domain_pwr,
    output logic o_rtc_osc_pwr,
    output logic o_cpu_run,
    output logic o_flash_ok
);
    localparam int SN = IRQ_N + 6;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_DPD, ST_WAKE} pwr_st_t;

    // pins and analog flags cross in through two flops
    logic [SN-1:0] sync1_reg;
    logic [SN-1:0] sync2_reg;
    logic rtc_1hz_d_reg;
    logic [4:0] ctrl_reg;
    logic [15:0] main_pll_reg;
    logic [15:0] alt_pll_reg;
    logic [3:0] clk_sel_reg;
    logic [15:0] clk_div_reg;
    logic [31:0] periph_reg;
    logic [IRQ_N-1:0] wake_mask_reg;
    cpm_pkg::clk_src_t cpu_src_reg;
    cpm_pkg::mode_t mode_reg;
    pwr_st_t st_reg;
    logic clock_output_pin_reg;
    logic rtc_tick_reg;
    logic wdt_en_reg;
    logic [31:0] rdata_reg;

    wire logic [IRQ_N-1:0] irq_s = sync2_reg[IRQ_N-1:0];
    wire logic main_lock_s = sync2_reg[IRQ_N];
    wire logic alt_lock_s = sync2_reg[IRQ_N+1];
    wire logic alarm_s = sync2_reg[IRQ_N+2];
    wire logic rtc_32k_s = sync2_reg[IRQ_N+3];
    wire logic rtc_1hz_s = sync2_reg[IRQ_N+4];
    wire logic wdt_osc_s = sync2_reg[IRQ_N+5];

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    wire logic wr_ctrl = i_we && hit(i_addr, cpm_pkg::CTRL_OFF);
    wire logic wr_main = i_we && hit(i_addr, cpm_pkg::MAIN_PLL_OFF);
    wire logic wr_alt = i_we && hit(i_addr, cpm_pkg::ALT_PLL_OFF);
    wire logic wr_sel = i_we && hit(i_addr, cpm_pkg::CLK_SEL_OFF);
    wire logic wr_div = i_we && hit(i_addr, cpm_pkg::CLK_DIV_OFF);
    wire logic wr_periph = i_we && hit(i_addr, cpm_pkg::PERIPH_PWR_OFF);
    wire logic wr_mode = i_we && hit(i_addr, cpm_pkg::PWR_MODE_OFF);
    wire cpm_pkg::mode_t req_mode = cpm_pkg::mode_t'(i_wdata[1:0]);
    wire logic enter_low = wr_mode && (req_mode != cpm_pkg::MODE_RUN) && (st_reg == ST_RUN);

    wire logic main_en = ctrl_reg[cpm_pkg::MAIN_EN_BIT];
    wire logic alt_en = ctrl_reg[cpm_pkg::ALT_EN_BIT];
    wire logic main_ready = main_en && main_lock_s;
    wire logic alt_ready = alt_en && alt_lock_s;
    wire cpm_pkg::clk_src_t want_src = cpm_pkg::clk_src_t'(clk_sel_reg[1:0]);
    wire cpm_pkg::clock_output_pin_t out_sel = cpm_pkg::clock_output_pin_t'(clk_sel_reg[3:2]);
    // a loop output is only taken once it is locked, so the mux never sees a ragged clock
    wire logic src_ok = (want_src == cpm_pkg::SRC_MAIN_PLL) ? main_ready :
                        (want_src == cpm_pkg::SRC_ALT_PLL) ? alt_ready : 1'b1;
    wire logic cur_ok = (cpu_src_reg == cpm_pkg::SRC_MAIN_PLL) ? main_ready :
                        (cpu_src_reg == cpm_pkg::SRC_ALT_PLL) ? alt_ready : 1'b1;
    wire logic wake_irq = |(irq_s & wake_mask_reg);
    wire logic dpd_exit = (st_reg == ST_DPD) && alarm_s;
    wire logic pd_wake = (st_reg == ST_SLEEP) && wake_irq;

    wire logic [7:0] main_div_raw = main_pll_reg[7:0];
    wire logic [7:0] alt_div_raw = alt_pll_reg[7:0];

    wake_if wk ();

    assign wk.sleep = enter_low;
    assign wk.wake = pd_wake || dpd_exit;
    assign wk.irc_used = (cpu_src_reg == cpm_pkg::SRC_IRC) ||
                         ((cpu_src_reg == cpm_pkg::SRC_MAIN_PLL) && !o_main_pll_ref_osc);

    wake_seq #(
        .START_CYC(START_CYC),
        .FLASH_CYC(FLASH_CYC)
    ) u_wake (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .wk(wk)
    );

    clk_div #(.W(8)) u_cpu_div (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_div(clk_div_reg[7:0]),
        .o_tick(o_cpu_clk_tick)
    );

    clk_div #(.W(8)) u_usb_div (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_div(clk_div_reg[15:8]),
        .o_tick(o_usb_clk_tick)
    );

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            rtc_1hz_d_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {i_wdt_osc, i_rtc_1hz, i_rtc_32k, i_rtc_alarm,
                          i_alt_pll_lock, i_main_pll_lock, i_irq_pend};
            sync2_reg <= sync1_reg;
            rtc_1hz_d_reg <= rtc_1hz_s;
        end
    end

    // config lives in the main domain and is lost when it is switched off
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ctrl_reg <= cpm_pkg::CTRL_RESET;
            main_pll_reg <= cpm_pkg::PLL_RESET;
            alt_pll_reg <= cpm_pkg::PLL_RESET;
            clk_sel_reg <= cpm_pkg::CLK_SEL_RESET;
            clk_div_reg <= cpm_pkg::CLK_DIV_RESET;
            periph_reg <= cpm_pkg::PERIPH_PWR_RESET;
        end
        else if (dpd_exit)
        begin
            ctrl_reg <= cpm_pkg::CTRL_RESET;
            main_pll_reg <= cpm_pkg::PLL_RESET;
            alt_pll_reg <= cpm_pkg::PLL_RESET;
            clk_sel_reg <= cpm_pkg::CLK_SEL_RESET;
            clk_div_reg <= cpm_pkg::CLK_DIV_RESET;
            periph_reg <= cpm_pkg::PERIPH_PWR_RESET;
        end
        else
        begin
            if (enter_low)
                ctrl_reg[1:0] <= 2'b00;
            else if (wr_ctrl)
                ctrl_reg <= i_wdata[4:0];
            if (wr_main)
                main_pll_reg <= i_wdata[15:0];
            if (wr_alt)
                alt_pll_reg <= i_wdata[15:0];
            if (wr_sel)
                clk_sel_reg <= i_wdata[3:0];
            if (wr_div)
                clk_div_reg <= i_wdata[15:0];
            if (wr_periph)
                periph_reg <= i_wdata;
        end
    end

    // current source follows the request only while the target is usable
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            cpu_src_reg <= cpm_pkg::SRC_IRC;
        else if (dpd_exit || enter_low)
            cpu_src_reg <= (dpd_exit || cpu_src_reg[1]) ? cpm_pkg::SRC_IRC : cpu_src_reg;
        else if (!cur_ok)
            cpu_src_reg <= cpm_pkg::SRC_IRC;
        else if (src_ok && o_cpu_clk_tick)
            cpu_src_reg <= want_src;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_reg <= ST_RUN;
            mode_reg <= cpm_pkg::MODE_RUN;
            wake_mask_reg <= '0;
        end
        else
        begin
            unique case (st_reg)
                ST_RUN:
                    if (enter_low)
                    begin
                        mode_reg <= req_mode;
                        wake_mask_reg <= i_irq_mask;
                        st_reg <= (req_mode == cpm_pkg::MODE_DEEP_PD) ? ST_DPD : ST_SLEEP;
                    end
                ST_SLEEP:
                    if (wake_irq)
                        st_reg <= ST_WAKE;
                ST_DPD:
                    if (alarm_s)
                        st_reg <= ST_WAKE;
                ST_WAKE:
                    if (wk.cpu_ok)
                    begin
                        st_reg <= ST_RUN;
                        mode_reg <= cpm_pkg::MODE_RUN;
                    end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            clock_output_pin_reg <= 1'b0;
            rtc_tick_reg <= 1'b0;
            wdt_en_reg <= 1'b0;
        end
        else
        begin
            unique case (out_sel)
                cpm_pkg::OUT_OFF: clock_output_pin_reg <= 1'b0;
                cpm_pkg::OUT_RTC_32K: clock_output_pin_reg <= rtc_32k_s;
                cpm_pkg::OUT_WDT_OSC: clock_output_pin_reg <= wdt_osc_s;
                cpm_pkg::OUT_CPU: clock_output_pin_reg <= o_cpu_clk_tick;
            endcase
            rtc_tick_reg <= rtc_1hz_s && !rtc_1hz_d_reg;
            wdt_en_reg <= i_wdt_en;
        end
    end

    // reads carry no side effects; unmapped offsets read zero
    wire logic [31:0] status_word = {16'h0000, 4'h0, 2'(st_reg), 2'(mode_reg),
                                     2'(cpu_src_reg), wk.flash_ok, wk.cpu_ok,
                                     alt_lock_s, main_lock_s, alt_ready, main_ready};
    wire logic [31:0] rd_mux =
        hit(i_addr, cpm_pkg::CTRL_OFF) ? {27'h0, ctrl_reg} :
        hit(i_addr, cpm_pkg::MAIN_PLL_OFF) ? {16'h0, main_pll_reg} :
        hit(i_addr, cpm_pkg::ALT_PLL_OFF) ? {16'h0, alt_pll_reg} :
        hit(i_addr, cpm_pkg::CLK_SEL_OFF) ? {28'h0, clk_sel_reg} :
        hit(i_addr, cpm_pkg::CLK_DIV_OFF) ? {16'h0, clk_div_reg} :
        hit(i_addr, cpm_pkg::PERIPH_PWR_OFF) ? periph_reg :
        hit(i_addr, cpm_pkg::PWR_MODE_OFF) ? {30'h0, 2'(mode_reg)} :
        hit(i_addr, cpm_pkg::STATUS_OFF) ? status_word : 32'h00000000;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_reg <= '0;
        else
            rdata_reg <= i_re ? rd_mux : 32'h00000000;
    end

    assign o_rdata = rdata_reg;
    assign o_main_pll_pd = !main_en;
    assign o_alt_pll_pd = !alt_en;
    assign o_main_pll_ref_osc = ctrl_reg[cpm_pkg::MAIN_REF_BIT];
    assign o_main_pll_mult = main_pll_reg[15:8];
    assign o_alt_pll_mult = alt_pll_reg[15:8];
    // odd duty cycles come from ratio one, so clamp up
    assign o_main_pll_div = (main_div_raw < cpm_pkg::PLL_DIV_MIN) ?
                            cpm_pkg::PLL_DIV_MIN : main_div_raw;
    assign o_alt_pll_div = (alt_div_raw < cpm_pkg::PLL_DIV_MIN) ?
                           cpm_pkg::PLL_DIV_MIN : alt_div_raw;
    assign o_cpu_src = 2'(cpu_src_reg);
    // usb falls back to the main loop unless the alternate is up and asked for
    assign o_usb_from_alt = ctrl_reg[cpm_pkg::USB_ALT_BIT] && alt_ready;
    assign o_clock_output_pin = clock_output_pin_reg;
    assign o_rtc_tick = rtc_tick_reg;
    assign o_wdt_osc_en = wdt_en_reg;
    assign o_periph_pwr_on = (st_reg == ST_DPD) ? 32'h00000000 : periph_reg;
    assign o_main_domain_pwr = (st_reg != ST_DPD);
    assign o_backup_domain_pwr = 1'b1;
    assign o_rtc_osc_pwr = (st_reg != ST_DPD) || ctrl_reg[cpm_pkg::KEEP_32K_BIT];
    assign o_cpu_run = (st_reg == ST_RUN);
    assign o_flash_ok = wk.flash_ok;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    loops_off_reset_a: assert property ($rose(i_reset_n) |-> o_main_pll_pd && o_alt_pll_pd)
        else $error("loops not powered down after reset");
    ref_change_a: assert property ($changed(o_main_pll_ref_osc) |-> $past(wr_ctrl || dpd_exit))
        else $error("main loop reference moved without a write");
    div_min_two_a: assert property (o_main_pll_div >= 8'h02 && o_alt_pll_div >= 8'h02)
        else $error("loop divider below two");
    usb_alt_route_a: assert property (o_usb_from_alt |-> !o_alt_pll_pd && alt_lock_s)
        else $error("usb taken from an idle alternate loop");
    irc_start_wait_a: assert property ((wk.wake && wk.irc_used) |=> !o_cpu_run [*8])
        else $error("cpu resumed before rc start-up");
    flash_block_a: assert property (wk.wake |=> !o_flash_ok [*8])
        else $error("flash opened too early after wake");
    dpd_power_off_a: assert property (st_reg == ST_DPD |-> !o_main_domain_pwr && o_backup_domain_pwr)
        else $error("main domain powered in deep power-down");
    dpd_hold_a: assert property (st_reg == ST_DPD && !alarm_s |=> st_reg == ST_DPD)
        else $error("deep power-down left without alarm");
    wake_irq_a: assert property (st_reg == ST_SLEEP && wake_irq |=> st_reg == ST_WAKE)
        else $error("masked interrupt did not wake");
    mask_capture_a: assert property (enter_low |=> wake_mask_reg == $past(i_irq_mask))
        else $error("wake mask not captured on entry");
    src_locked_a: assert property ($changed(o_cpu_src) && o_cpu_src[1] |->
        (o_cpu_src[0] ? $past(alt_ready) : $past(main_ready)))
        else $error("loop selected while unlocked");
    src_drop_a: assert property (o_cpu_src[1] && !(o_cpu_src[0] ? alt_ready : main_ready)
        |=> !o_cpu_src[1])
        else $error("unlocked loop kept as cpu source");
endmodule

// File: rtl/cpm_pkg.sv
package cpm_pkg;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] MAIN_PLL_OFF = 8'h04;
    localparam logic [7:0] ALT_PLL_OFF = 8'h08;
    localparam logic [7:0] CLK_SEL_OFF = 8'h0c;
    localparam logic [7:0] CLK_DIV_OFF = 8'h10;
    localparam logic [7:0] PERIPH_PWR_OFF = 8'h14;
    localparam logic [7:0] PWR_MODE_OFF = 8'h18;
    localparam logic [7:0] STATUS_OFF = 8'h1c;
    localparam int MAIN_EN_BIT = 0;
    localparam int ALT_EN_BIT = 1;
    localparam int MAIN_REF_BIT = 2;
    localparam int USB_ALT_BIT = 3;
    localparam int KEEP_32K_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [15:0] PLL_RESET = 16'h0102;
    localparam logic [7:0] PLL_DIV_MIN = 8'h02;
    localparam logic [3:0] CLK_SEL_RESET = 4'h0;
    localparam logic [15:0] CLK_DIV_RESET = 16'h0101;
    localparam logic [31:0] PERIPH_PWR_RESET = 32'h00000000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int IRC_START_NS = 60000;
    localparam int IRC_START_CYC = (IRC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int IRC_FREQ_KHZ = 12000;
    localparam int IRC_RESUME_CYCLES = 4;
    localparam int IRC_RESUME_CYC =
        (IRC_RESUME_CYCLES * CLK_FREQ_KHZ + IRC_FREQ_KHZ - 1) / IRC_FREQ_KHZ;
    localparam int FLASH_START_NS = 100000;
    localparam int FLASH_START_CYC =
        (FLASH_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    typedef enum logic [1:0] {SRC_IRC, SRC_OSC, SRC_MAIN_PLL, SRC_ALT_PLL} clk_src_t;
    typedef enum logic [1:0] {MODE_RUN, MODE_DEEP_SLEEP, MODE_POWER_DOWN, MODE_DEEP_PD} mode_t;
    typedef enum logic [1:0] {OUT_OFF, OUT_RTC_32K, OUT_WDT_OSC, OUT_CPU} clock_output_pin_t;
endpackage

// File: rtl/wake_if.sv
`timescale 1ns/1ps
interface wake_if;
    logic sleep;
    logic wake;
    logic irc_used;
    logic cpu_ok;
    logic flash_ok;
    modport ctrl (output sleep, output wake, output irc_used, input cpu_ok, input flash_ok);
    modport seq (input sleep, input wake, input irc_used, output cpu_ok, output flash_ok);
endinterface

// File: rtl/wake_seq.sv
`timescale 1ns/1ps
module wake_seq #(
    parameter int START_CYC = cpm_pkg::IRC_START_CYC,
    parameter int FLASH_CYC = cpm_pkg::FLASH_START_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    wake_if.seq wk
);
    localparam int CW = $clog2(FLASH_CYC + START_CYC + cpm_pkg::IRC_RESUME_CYC + 2);
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_IRC_START, SEQ_IRC_CYC, SEQ_DONE} seq_t;
    seq_t st_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] fl_reg;
    logic cpu_ok_reg;
    logic flash_ok_reg;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_reg <= SEQ_DONE;
            cnt_reg <= '0;
            fl_reg <= '0;
            cpu_ok_reg <= 1'b1;
            flash_ok_reg <= 1'b1;
        end
        else if (wk.sleep)
        begin
            st_reg <= SEQ_IDLE;
            cpu_ok_reg <= 1'b0;
            flash_ok_reg <= 1'b0;
        end
        else if (wk.wake)
        begin
            st_reg <= wk.irc_used ? SEQ_IRC_START : SEQ_IRC_CYC;
            cnt_reg <= wk.irc_used ? CW'(START_CYC - 1) : CW'(cpm_pkg::IRC_RESUME_CYC - 1);
            fl_reg <= CW'(FLASH_CYC - 1);
        end
        else
        begin
            if (fl_reg != '0)
                fl_reg <= fl_reg - CW'(1);
            else if (st_reg != SEQ_IDLE)
                flash_ok_reg <= 1'b1;
            unique case (st_reg)
                SEQ_IDLE, SEQ_DONE: ;
                SEQ_IRC_START:
                    if (cnt_reg == '0)
                    begin
                        st_reg <= SEQ_IRC_CYC;
                        cnt_reg <= CW'(cpm_pkg::IRC_RESUME_CYC - 1);
                    end
                    else
                        cnt_reg <= cnt_reg - CW'(1);
                SEQ_IRC_CYC:
                    if (cnt_reg == '0)
                    begin
                        st_reg <= SEQ_DONE;
                        cpu_ok_reg <= 1'b1;
                    end
                    else
                        cnt_reg <= cnt_reg - CW'(1);
            endcase
        end
    end

    assign wk.cpu_ok = cpu_ok_reg;
    assign wk.flash_ok = flash_ok_reg;
endmodule

// File: test/soc_env_model.sv
`timescale 1ns/1ps
module soc_env_model #(
    parameter int LOCK_CYC = 30
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_main_pll_pd,
    input wire logic i_alt_pll_pd,
    output logic o_main_pll_lock,
    output logic o_alt_pll_lock,
    output logic o_rtc_32k,
    output logic o_rtc_1hz,
    output logic o_wdt_osc
);
    int main_cnt;
    int alt_cnt;
    int slow_cnt;
    // lock needs a full settle time; power-down drops it at once, as a real loop would
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            main_cnt <= 0;
            alt_cnt <= 0;
            slow_cnt <= 0;
        end
        else
        begin
            main_cnt <= i_main_pll_pd ? 0 : ((main_cnt < LOCK_CYC) ? main_cnt + 1 : main_cnt);
            alt_cnt <= i_alt_pll_pd ? 0 : ((alt_cnt < LOCK_CYC) ? alt_cnt + 1 : alt_cnt);
            slow_cnt <= (slow_cnt == 299) ? 0 : slow_cnt + 1;
        end
    end
    assign o_main_pll_lock = (main_cnt >= LOCK_CYC);
    assign o_alt_pll_lock = (alt_cnt >= LOCK_CYC);
    // slow clocks scaled down to keep the run short
    assign o_rtc_32k = ((slow_cnt / 3) % 2) == 1;
    assign o_rtc_1hz = ((slow_cnt / 50) % 2) == 1;
    assign o_wdt_osc = ((slow_cnt / 5) % 2) == 1;
endmodule

// File: test/test_clock_power_manager.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module test_clock_power_manager;
    localparam int START = 20;
    localparam int FLASH = 200;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_we = 1'b0, i_re = 1'b0;
    logic i_rtc_alarm = 1'b0, i_wdt_en = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, i_irq_pend = 32'h0, i_irq_mask = 32'h0;
    logic i_main_pll_lock, i_alt_pll_lock, i_rtc_32k, i_rtc_1hz, i_wdt_osc;
    logic [31:0] o_rdata, o_periph_pwr_on;
    logic o_main_pll_pd, o_alt_pll_pd, o_main_pll_ref_osc, o_cpu_clk_tick, o_usb_from_alt;
    logic o_usb_clk_tick, o_clock_output_pin, o_rtc_tick, o_wdt_osc_en, o_main_domain_pwr;
    logic o_backup_domain_pwr, o_rtc_osc_pwr, o_cpu_run, o_flash_ok;
    logic [7:0] o_main_pll_mult, o_main_pll_div, o_alt_pll_mult, o_alt_pll_div;
    logic [1:0] o_cpu_src;
    int num_errors = 0;
    int tests_run = 0;
    int c, n, tr, tf, e;
    clock_power_manager #(.START_CYC(START), .FLASH_CYC(FLASH)) i_clock_power_manager (
        .i_clk, .i_reset_n, .i_addr, .i_wdata, .i_we, .i_re, .i_main_pll_lock,
        .i_alt_pll_lock, .i_irq_pend, .i_irq_mask, .i_rtc_alarm, .i_rtc_32k, .i_rtc_1hz,
        .i_wdt_osc, .i_wdt_en, .o_rdata, .o_main_pll_pd, .o_alt_pll_pd, .o_main_pll_ref_osc,
        .o_main_pll_mult, .o_main_pll_div, .o_alt_pll_mult, .o_alt_pll_div, .o_cpu_src,
        .o_cpu_clk_tick, .o_usb_from_alt, .o_usb_clk_tick, .o_clock_output_pin, .o_rtc_tick,
        .o_wdt_osc_en, .o_periph_pwr_on, .o_main_domain_pwr, .o_backup_domain_pwr,
        .o_rtc_osc_pwr, .o_cpu_run, .o_flash_ok);
    soc_env_model i_soc_env_model (
        .i_clk, .i_reset_n, .i_main_pll_pd(o_main_pll_pd), .i_alt_pll_pd(o_alt_pll_pd),
        .o_main_pll_lock(i_main_pll_lock), .o_alt_pll_lock(i_alt_pll_lock),
        .o_rtc_32k(i_rtc_32k), .o_rtc_1hz(i_rtc_1hz), .o_wdt_osc(i_wdt_osc));
    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end
    task conclude;
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_we <= 1'b1;
        @(posedge i_clk);
        i_we <= 1'b0;
        #1;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_re <= 1'b1;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1 `CHK(o_rdata, exp)
    endtask
    // sel: 0 cpu tick, 1 usb tick, 2 clock-out toggles, 3 rtc tick
    task count(input int sel, input int cyc, output int cnt);
        logic last;
        cnt = 0;
        last = o_clock_output_pin;
        repeat (cyc)
        begin
            @(posedge i_clk);
            #1;
            case (sel)
                0: cnt += (o_cpu_clk_tick === 1'b1);
                1: cnt += (o_usb_clk_tick === 1'b1);
                2: cnt += (o_clock_output_pin !== last);
                default: cnt += (o_rtc_tick === 1'b1);
            endcase
            last = o_clock_output_pin;
        end
    endtask
    // sel 0 waits on the cpu source, sel 1 on the run flag
    task wait_until(input int sel, input logic [1:0] v, input int lim);
        n = 0;
        while (((sel == 0) ? (o_cpu_src !== v) : (o_cpu_run !== v[0])) && n < lim)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= lim)
        begin
            num_errors++;
            conclude();
        end
    endtask
    initial
    begin
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        #1 `CHK({o_main_pll_pd, o_alt_pll_pd}, 2'b11)
        `CHK(o_backup_domain_pwr, 1'b1)
        `CHK(o_wdt_osc_en, 1'b0)
        rd_chk(cpm_pkg::CTRL_OFF, 32'h0);
        rd_chk(cpm_pkg::MAIN_PLL_OFF, {16'h0, cpm_pkg::PLL_RESET});
        rd_chk(cpm_pkg::CLK_DIV_OFF, {16'h0, cpm_pkg::CLK_DIV_RESET});
        rd_chk(cpm_pkg::PERIPH_PWR_OFF, 32'h0);
        wr(8'h20, 32'hffff_ffff);
        rd_chk(8'h20, 32'h0);
        for (int d = 0; d < 4; d++)
        begin
            wr(cpm_pkg::MAIN_PLL_OFF, {16'h0, 8'h18, d[7:0]});
            wr(cpm_pkg::ALT_PLL_OFF, {16'h0, 8'h18, d[7:0]});
            `CHK(o_main_pll_div, (d < 2) ? cpm_pkg::PLL_DIV_MIN : d[7:0])
            `CHK(o_alt_pll_div, (d < 2) ? cpm_pkg::PLL_DIV_MIN : d[7:0])
            `CHK({o_main_pll_mult, o_alt_pll_mult}, 16'h1818)
        end
        wr(cpm_pkg::CTRL_OFF, 32'h4);
        `CHK(o_main_pll_ref_osc, 1'b1)
        wr(cpm_pkg::CTRL_OFF, 32'h8);
        `CHK({o_main_pll_ref_osc, o_usb_from_alt}, 2'b00)
        wr(cpm_pkg::CTRL_OFF, 32'ha);
        repeat (40) @(posedge i_clk);
        #1 `CHK(o_usb_from_alt, 1'b1)
        wr(cpm_pkg::CTRL_OFF, 32'h0);
        `CHK(o_usb_from_alt, 1'b0)
        wr(cpm_pkg::PERIPH_PWR_OFF, 32'ha5c3_0f1e);
        `CHK(o_periph_pwr_on, 32'ha5c3_0f1e)
        wr(cpm_pkg::CLK_DIV_OFF, 32'h0403);
        count(0, 60, c);
        `CHK(c, 20)
        count(1, 60, c);
        `CHK(c, 15)
        // clock-out sources: off, slow rtc clock, watchdog oscillator
        for (int s = 0; s < 3; s++)
        begin
            wr(cpm_pkg::CLK_SEL_OFF, {28'h0, s[1:0], 2'b00});
            count(2, 120, c);
            e = (s == 0) ? 0 : ((s == 1) ? 40 : 24);
            `CHK(c >= e - 1 && c <= e + 1, 1'b1)
        end
        count(3, 400, c);
        `CHK(c, 4)
        // switching to a loop must wait for its lock, and unlock falls back
        for (int p = 0; p < 2; p++)
        begin
            wr(cpm_pkg::CTRL_OFF, 32'h1 << p);
            wr(cpm_pkg::CLK_SEL_OFF, 32'h2 + p);
            `CHK(o_cpu_src, 2'd0)
            wait_until(0, 2'd2 + p[1:0], 100);
            wr(cpm_pkg::CTRL_OFF, 32'h0);
            wait_until(0, 2'd0, 20);
        end
        @(posedge i_clk);
        i_wdt_en <= 1'b1;
        i_irq_mask <= 32'h20;
        wr(cpm_pkg::CLK_SEL_OFF, 32'h0);
        wr(cpm_pkg::CTRL_OFF, 32'h1);
        wr(cpm_pkg::PWR_MODE_OFF, 32'h2);
        @(posedge i_clk);
        #1 `CHK({o_cpu_run, o_flash_ok, o_main_pll_pd}, 3'b001)
        `CHK(o_wdt_osc_en, 1'b1)
        @(posedge i_clk);
        i_irq_pend <= 32'h08;
        repeat (50) @(posedge i_clk);
        #1 `CHK(o_cpu_run, 1'b0)
        @(posedge i_clk);
        i_irq_pend <= 32'h28;
        n = 0;
        tr = 0;
        tf = 0;
        while ((tr == 0 || tf == 0) && n < 1000)
        begin
            @(posedge i_clk);
            #1;
            n++;
            if (o_cpu_run === 1'b1 && tr == 0)
                tr = n;
            if (o_flash_ok === 1'b1 && tf == 0)
                tf = n;
        end
        @(posedge i_clk);
        i_irq_pend <= 32'h0;
        `CHK(tr >= START + 68 && tr <= START + 72, 1'b1)
        `CHK(tf >= FLASH + 1 && tf <= FLASH + 5, 1'b1)
        rd_chk(cpm_pkg::CTRL_OFF, 32'h0);
        // deep power-down, slow oscillator kept then dropped
        for (int k = 1; k >= 0; k--)
        begin
            wr(cpm_pkg::CLK_DIV_OFF, 32'h0203);
            wr(cpm_pkg::CTRL_OFF, {27'h0, k[0], 4'h0});
            wr(cpm_pkg::PWR_MODE_OFF, 32'h3);
            @(posedge i_clk);
            #1 `CHK({o_main_domain_pwr, o_backup_domain_pwr}, 2'b01)
            `CHK(o_rtc_osc_pwr, k[0])
            @(posedge i_clk);
            i_irq_pend <= 32'h20;
            repeat (START + 100) @(posedge i_clk);
            #1 `CHK(o_cpu_run, 1'b0)
            @(posedge i_clk);
            i_irq_pend <= 32'h0;
            i_rtc_alarm <= 1'b1;
            wait_until(1, 2'd1, 2000);
            `CHK(o_main_domain_pwr, 1'b1)
            @(posedge i_clk);
            i_rtc_alarm <= 1'b0;
            rd_chk(cpm_pkg::CLK_DIV_OFF, {16'h0, cpm_pkg::CLK_DIV_RESET});
        end
        conclude();
    end
endmodule
